/* File: src/apfm_pkg.sv */
// Package: register layout, field positions, reset values and timing for the aux pin mux
//------------------------------------------------------------
// Operation
// R1 - With the channel-to-pin enable set, the active channel number is shown on the four pins.
// R2 - The channel number is plain binary, pin 3 the most significant bit, sixteen values.
// R3 - With the enable cleared (its reset value) the channel number is not put on the pins.
// R4 - While continuous transmit is active, aux pin b carries the stream data clock.
// R5 - Aux pin b function 00 (reset) leaves the pin high impedance; 01 and 11 are reserved.
// R6 - Aux pin b function 10 makes the pin an external start input.
// R7 - Software selects start on pin b only together with sync output on pin a.
// R8 - In start mode the sync output is a copy of start retimed to the main clock.
// R9 - Start to sync output takes 3-4 edges at divide 2, 5-8 at divide 4, 9-16 at divide 8.
// R10 - Aux pin a function 00 (reset) keeps the pin high impedance.
// R11 - Aux pin a function 01 drives the pin as an active-low result-ready indicator.
// R12 - While ready is on pin a, the serial data pin stops signalling ready.
// R13 - Aux pin a function 10 drives the pin as the sync output; 11 is reserved.
// R14 - Any write to the configuration register resets filter, control logic and sequencer.
// R15 - In default sync mode a low sync input holds modulator, filter, control, sequencer in reset.
// R16 - Reserved bits 15 and 13 to 8 read as zero and ignore writes.
package apfm_pkg;

	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 16;
	localparam logic [7:0]  PIN_FUNC_CFG_ADDR = 8'h68;
	localparam logic [15:0] PIN_FUNC_CFG_RST  = 16'h0004;
	localparam logic [15:0] PIN_FUNC_CFG_WMSK = 16'h40FF;

	localparam int          CH_TO_PINS_BIT    = 14;
	localparam int          AUX_B_FUNC_HI     = 7;
	localparam int          AUX_B_FUNC_LO     = 6;
	localparam int          AUX_A_FUNC_HI     = 5;
	localparam int          AUX_A_FUNC_LO     = 4;
	localparam int          SYNC_MODE_HI      = 3;
	localparam int          SYNC_MODE_LO      = 2;
	localparam int          DRIVE_BOOST_BIT   = 1;
	localparam int          READY_REL_BIT     = 0;

	localparam logic [1:0]  AUX_B_HIZ         = 2'h0;
	localparam logic [1:0]  AUX_B_START       = 2'h2;
	localparam logic [1:0]  AUX_A_HIZ         = 2'h0;
	localparam logic [1:0]  AUX_A_READY       = 2'h1;
	localparam logic [1:0]  AUX_A_SYNC        = 2'h2;
	localparam logic [1:0]  SYNC_MODE_DEFAULT = 2'h1;

	// Main clock divide select codes
	localparam logic [1:0]  DIV_BY_2          = 2'h0;
	localparam logic [1:0]  DIV_BY_4          = 2'h1;
	localparam logic [1:0]  DIV_BY_8          = 2'h2;
	localparam logic [3:0]  DIV2_TC           = 4'h1;
	localparam logic [3:0]  DIV4_TC           = 4'h3;
	localparam logic [3:0]  DIV8_TC           = 4'h7;
	localparam int          CH_W              = 4;

endpackage

/* File: src/apfm_sync_if.sv */
// Interface: start-to-sync retimer signals between top and retimer
`timescale 1ns/1ps
interface apfm_sync_if;
	logic       start;
	logic [1:0] div_sel;
	logic       enable;
	logic       sync;

	modport ctrl (output start, output div_sel, output enable, input sync);
	modport retm (input start, input div_sel, input enable, output sync);
endinterface

/* File: src/apfm_start_retimer.sv */
// Retimer of the start input onto divided main-clock phases
`timescale 1ns/1ps
module apfm_start_retimer
	import apfm_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	apfm_sync_if.retm sif
);
	typedef struct packed {
		logic [3:0] phase;
		logic       s1;
		logic       sync;
	} apfm_rt_state_t;

	apfm_rt_state_t st_reg;
	apfm_rt_state_t st_next;

	function automatic logic [3:0] div_tc(input logic [1:0] sel);
		unique case (sel)
			DIV_BY_4: div_tc = DIV4_TC;
			DIV_BY_8: div_tc = DIV8_TC;
			default:  div_tc = DIV2_TC;
		endcase
	endfunction

	// Sample on a divided tick, output on the next tick: 3..4 / 5..8 / 9..16 edges
	// Next value is handed out so the pin register in the top is the last stage
	always_comb begin
		logic tick;
		tick    = 1'b0;
		st_next = st_reg;
		tick    = (st_reg.phase == div_tc(sif.div_sel));
		st_next.phase = tick ? 4'h0 : st_reg.phase + 4'h1;
		if (!sif.enable) begin
			st_next.s1   = 1'b0;
			st_next.sync = 1'b0;
		end else if (tick) begin // [R8] [R9]
			st_next.s1   = sif.start;
			st_next.sync = st_reg.s1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else if (ce_in) begin
			st_reg <= st_next;
		end
	end

	assign sif.sync = st_next.sync;
endmodule

/* File: src/apfm_aux_pin_mux.sv */
// Top: pin function configuration register and auxiliary pin multiplexing
`timescale 1ns/1ps
module apfm_aux_pin_mux
	import apfm_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [DATA_W-1:0] rdata_out,
	input  wire logic [CH_W-1:0]   active_channel_in,
	input  wire logic              cont_tx_in,
	input  wire logic              stream_data_clock_in,
	input  wire logic              ready_n_in,
	input  wire logic [1:0]        clk_div_sel_in,
	input  wire logic              sync_in_n_in,
	input  wire logic              aux_pin_b_in,
	output logic                   aux_pin_b_out,
	output logic                   aux_pin_b_oe_n_out,
	output logic                   aux_pin_a_out,
	output logic                   aux_pin_a_oe_n_out,
	output logic [CH_W-1:0]        gp_pins_out,
	output logic [CH_W-1:0]        gp_pins_oe_n_out,
	output logic                   sdo_ready_en_out,
	output logic                   output_drive_boost_out,
	output logic                   ready_release_select_out,
	output logic                   core_reset_out,
	output logic                   modulator_reset_out
);
	typedef struct packed {
		logic [DATA_W-1:0] cfg;
		logic [DATA_W-1:0] rdata;
		logic              b_out;
		logic              b_oe_n;
		logic              a_out;
		logic              a_oe_n;
		logic [CH_W-1:0]   gp;
		logic [CH_W-1:0]   gp_oe_n;
		logic              sdo_rdy;
		logic              core_rst;
		logic              mod_rst;
	} apfm_state_t;

	apfm_state_t st_reg;
	apfm_state_t st_next;
	apfm_sync_if sif ();

	//------------------------------------------------------------
	// Start retimer
	//------------------------------------------------------------
	apfm_start_retimer u_retimer (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.ce_in  (ce_in),
		.sif    (sif)
	);

	always_comb begin
		logic [1:0] b_fn;
		logic [1:0] a_fn;
		logic       start_mode;
		b_fn       = st_reg.cfg[AUX_B_FUNC_HI:AUX_B_FUNC_LO];
		a_fn       = st_reg.cfg[AUX_A_FUNC_HI:AUX_A_FUNC_LO];
		start_mode = !cont_tx_in && (b_fn == AUX_B_START);
		sif.start   = aux_pin_b_in;
		sif.div_sel = clk_div_sel_in;
		sif.enable  = start_mode && (a_fn == AUX_A_SYNC); // [R7]
	end

	//------------------------------------------------------------
	// Register and pin next state
	//------------------------------------------------------------
	always_comb begin
		logic [1:0] b_fn;
		logic [1:0] a_fn;
		logic       cfg_wr;
		b_fn    = st_reg.cfg[AUX_B_FUNC_HI:AUX_B_FUNC_LO];
		a_fn    = st_reg.cfg[AUX_A_FUNC_HI:AUX_A_FUNC_LO];
		cfg_wr  = wr_in && (addr_in == PIN_FUNC_CFG_ADDR);
		st_next = st_reg;
		if (cfg_wr) begin
			st_next.cfg = wdata_in & PIN_FUNC_CFG_WMSK; // [R16]
		end
		st_next.rdata = (rd_in && addr_in == PIN_FUNC_CFG_ADDR) ? st_reg.cfg : '0;

		// Pin b: stream clock overrides field
		if (cont_tx_in) begin // [R4]
			st_next.b_out  = stream_data_clock_in;
			st_next.b_oe_n = 1'b0;
		end else begin // [R5] [R6]
			st_next.b_out  = 1'b0;
			st_next.b_oe_n = 1'b1;
		end

		unique case (a_fn)
			AUX_A_READY: begin // [R11]
				st_next.a_out  = ready_n_in;
				st_next.a_oe_n = 1'b0;
			end
			AUX_A_SYNC: begin // [R13]
				st_next.a_out  = sif.sync;
				st_next.a_oe_n = 1'b0;
			end
			default: begin // [R10]
				st_next.a_out  = 1'b0;
				st_next.a_oe_n = 1'b1;
			end
		endcase
		st_next.sdo_rdy = (a_fn != AUX_A_READY); // [R12]

		if (st_reg.cfg[CH_TO_PINS_BIT]) begin // [R1] [R2]
			st_next.gp      = active_channel_in;
			st_next.gp_oe_n = '0;
		end else begin // [R3]
			st_next.gp      = '0;
			st_next.gp_oe_n = '1;
		end

		st_next.mod_rst  = (st_reg.cfg[SYNC_MODE_HI:SYNC_MODE_LO] == SYNC_MODE_DEFAULT)
			&& !sync_in_n_in; // [R15]
		st_next.core_rst = cfg_wr || st_next.mod_rst; // [R14] [R15]
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_reg         <= '0;
			st_reg.cfg     <= PIN_FUNC_CFG_RST;
			st_reg.b_oe_n  <= 1'b1;
			st_reg.a_oe_n  <= 1'b1;
			st_reg.gp_oe_n <= '1;
			st_reg.sdo_rdy <= 1'b1;
		end else if (ce_in) begin
			st_reg <= st_next;
		end
	end

	//------------------------------------------------------------
	// Outputs straight from flip-flops
	//------------------------------------------------------------
	assign rdata_out                = st_reg.rdata;
	assign aux_pin_b_out            = st_reg.b_out;
	assign aux_pin_b_oe_n_out       = st_reg.b_oe_n;
	assign aux_pin_a_out            = st_reg.a_out;
	assign aux_pin_a_oe_n_out       = st_reg.a_oe_n;
	assign gp_pins_out              = st_reg.gp;
	assign gp_pins_oe_n_out         = st_reg.gp_oe_n;
	assign sdo_ready_en_out         = st_reg.sdo_rdy;
	assign output_drive_boost_out   = st_reg.cfg[DRIVE_BOOST_BIT];
	assign ready_release_select_out = st_reg.cfg[READY_REL_BIT];
	assign core_reset_out           = st_reg.core_rst;
	assign modulator_reset_out      = st_reg.mod_rst;
endmodule

/* File: tb/apfm_aux_pin_mux_asserts.sv */
// Checker: port-level properties of the aux pin mux
`timescale 1ns/1ps
module apfm_aux_pin_mux_asserts
	import apfm_pkg::*;
(
	input wire logic        clk_in, rst_in, ce_in, wr_in, rd_in, cont_tx_in, stream_data_clock_in,
	input wire logic        ready_n_in, sync_in_n_in, aux_pin_b_in, aux_pin_b_out,
	input wire logic        aux_pin_b_oe_n_out, aux_pin_a_out, aux_pin_a_oe_n_out,
	input wire logic        sdo_ready_en_out, core_reset_out, modulator_reset_out,
	input wire logic [1:0]  clk_div_sel_in,
	input wire logic [3:0]  active_channel_in, gp_pins_out, gp_pins_oe_n_out,
	input wire logic [7:0]  addr_in,
	input wire logic [15:0] wdata_in, rdata_out
);
	logic [15:0] cfg_reg;
	//----------
	// Shadow of the configuration word
	//----------
	always_ff @(posedge clk_in) begin
		if (rst_in)
			cfg_reg <= PIN_FUNC_CFG_RST;
		else if (ce_in && wr_in && addr_in == PIN_FUNC_CFG_ADDR)
			cfg_reg <= wdata_in & PIN_FUNC_CFG_WMSK;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_armed;
		cfg_reg[7:6] == AUX_B_START && cfg_reg[5:4] == AUX_A_SYNC && !cont_tx_in;
	endsequence
	sequence s_start_div2;
		$rose(aux_pin_b_in) && clk_div_sel_in == DIV_BY_2;
	endsequence
	property p_read; rd_in && addr_in == PIN_FUNC_CFG_ADDR |=> rdata_out == cfg_reg; endproperty
	property p_wr_rst; wr_in && addr_in == PIN_FUNC_CFG_ADDR |=> core_reset_out; endproperty
	property p_gp_on; cfg_reg[CH_TO_PINS_BIT] |=>
		!gp_pins_oe_n_out && gp_pins_out == $past(active_channel_in); endproperty
	property p_gp_off; !cfg_reg[CH_TO_PINS_BIT] |=> gp_pins_oe_n_out == 4'hF; endproperty
	property p_stream; cont_tx_in |=>
		!aux_pin_b_oe_n_out && aux_pin_b_out == $past(stream_data_clock_in); endproperty
	property p_ready; cfg_reg[5:4] == AUX_A_READY |=> !aux_pin_a_oe_n_out
		&& !sdo_ready_en_out && aux_pin_a_out == $past(ready_n_in); endproperty
	property p_hold; cfg_reg[3:2] == SYNC_MODE_DEFAULT && !sync_in_n_in |=>
		core_reset_out && modulator_reset_out; endproperty
	property p_sync; s_armed ##0 s_start_div2 |-> ##[2:3] aux_pin_a_out; endproperty
	a_read: assert property (p_read) else $error("read data");
	a_wr_rst: assert property (p_wr_rst) else $error("write reset");
	a_gp_on: assert property (p_gp_on) else $error("channel pins");
	a_gp_off: assert property (p_gp_off) else $error("pins off");
	a_stream: assert property (p_stream) else $error("stream clock");
	a_ready: assert property (p_ready) else $error("ready pin");
	a_hold: assert property (p_hold) else $error("sync hold");
	a_sync: assert property (p_sync) else $error("sync latency");
endmodule
bind apfm_aux_pin_mux apfm_aux_pin_mux_asserts CHK (.*);

/* File: tb/apfm_far_side.sv */
// Far-side model: start source on aux pin b and external channel multiplexer
`timescale 1ns/1ps
module apfm_far_side (
	input  wire logic       clk_in,
	input  wire logic       start_en_in,
	input  wire logic       start_in,
	input  wire logic       pin_b_oe_n_in,
	input  wire logic       pin_b_dev_in,
	input  wire logic [3:0] gp_in,
	input  wire logic [3:0] gp_oe_n_in,
	output logic            pin_b_out,
	output logic [3:0]      mux_sel_out
);
	logic       b_last_reg = 1'b0;
	logic [3:0] sel_last_reg = 4'h0;
	// Undriven lines show the inverse of their last level; pin b shows start while start_en_in is set
	always_ff @(posedge clk_in) begin
		b_last_reg   <= pin_b_out;
		sel_last_reg <= mux_sel_out;
	end
	assign pin_b_out   = !pin_b_oe_n_in ? pin_b_dev_in : (start_en_in ? start_in : ~b_last_reg);
	assign mux_sel_out = (gp_oe_n_in == 4'h0) ? gp_in : ~sel_last_reg;
endmodule

/* File: tb/test_apfm_aux_pin_mux.sv */
// Testbench: directed scenarios for the aux pin mux
`timescale 1ns/1ps
module test_apfm_aux_pin_mux
	import apfm_pkg::*;
;
	logic        clk_in, rst_in, ce_in, wr_in, rd_in, cont_tx_in, stream_data_clock_in;
	logic        ready_n_in, sync_in_n_in, aux_pin_b_in, aux_pin_b_out, aux_pin_b_oe_n_out;
	logic        aux_pin_a_out, aux_pin_a_oe_n_out, sdo_ready_en_out, output_drive_boost_out;
	logic        ready_release_select_out, core_reset_out, modulator_reset_out, start_en, start;
	logic [1:0]  clk_div_sel_in;
	logic [3:0]  active_channel_in, gp_pins_out, gp_pins_oe_n_out, mux_sel;
	logic [7:0]  addr_in;
	logic [15:0] wdata_in, rdata_out, rd_val;
	int          n_mismatch = 0;
	int          n_checks = 0;
	apfm_aux_pin_mux DUT (.*);
	apfm_far_side FAR (.clk_in, .start_en_in(start_en), .start_in(start),
		.pin_b_oe_n_in(aux_pin_b_oe_n_out), .pin_b_dev_in(aux_pin_b_out), .gp_in(gp_pins_out),
		.gp_oe_n_in(gp_pins_oe_n_out), .pin_b_out(aux_pin_b_in), .mux_sel_out(mux_sel));
	//----------
	// Shared tasks
	//----------
	task automatic chk(input string nm, input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 rd_val = rdata_out;
	endtask
	//----------
	// Scenarios
	//----------
	task automatic t_regs;
		rd(PIN_FUNC_CFG_ADDR);
		chk("cfg reset", rd_val, 16'h0004);
		chk("idle", {aux_pin_b_oe_n_out, aux_pin_a_oe_n_out, gp_pins_oe_n_out}, 16'h003F);
		wr(PIN_FUNC_CFG_ADDR, 16'hFFFF);
		tick(0);
		chk("core reset", core_reset_out, 16'h0001);
		wr(8'h69, 16'h0000);
		rd(PIN_FUNC_CFG_ADDR);
		chk("cfg mask", rd_val, 16'h40FF);
		chk("low bits", {output_drive_boost_out, ready_release_select_out}, 16'h0003);
		rd(8'h6A);
		chk("unmapped", rd_val, 16'h0000);
		$display("register test end");
	endtask
	task automatic t_chan;
		wr(PIN_FUNC_CFG_ADDR, 16'h4004);
		for (int c = 0; c < 16; c++) begin
			@(posedge clk_in);
			active_channel_in <= 4'(c);
			tick(1);
			chk("gp pins", gp_pins_out, 16'(c));
			chk("ext mux", mux_sel, 16'(c));
		end
		wr(PIN_FUNC_CFG_ADDR, 16'h0004);
		tick(1);
		chk("gp off", gp_pins_oe_n_out, 16'h000F);
		$display("channel test end");
	endtask
	task automatic t_aux;
		for (int k = 0; k < 4; k++) begin
			wr(PIN_FUNC_CFG_ADDR, 16'h0004 | 16'(k << 4));
			tick(1);
			chk("a drive", aux_pin_a_oe_n_out, 16'(k == 0 || k == 3));
			chk("sdo ready", sdo_ready_en_out, 16'(k != 1));
			if (k == 1) begin
				@(posedge clk_in);
				ready_n_in <= 1'b1;
				tick(1);
				chk("ready pin", aux_pin_a_out, 16'h0001);
			end
		end
		$display("aux pin test end");
	endtask
	task automatic t_stream;
		@(posedge clk_in);
		cont_tx_in <= 1'b1;
		wr(PIN_FUNC_CFG_ADDR, 16'h00A4);
		for (int v = 0; v < 4; v++) begin
			@(posedge clk_in);
			stream_data_clock_in <= v[0];
			tick(1);
			chk("b clock", {aux_pin_b_oe_n_out, aux_pin_b_out}, 16'(v[0]));
		end
		wr(PIN_FUNC_CFG_ADDR, 16'h0004);
		@(posedge clk_in);
		cont_tx_in <= 1'b0;
		$display("stream test end");
	endtask
	task automatic t_start(input logic [1:0] dv, input int lo, input int hi);
		int n;
		@(posedge clk_in);
		clk_div_sel_in <= dv;
		start_en       <= 1'b1;
		wr(PIN_FUNC_CFG_ADDR, 16'h00A4);
		tick(20);
		chk("b input", {aux_pin_b_oe_n_out, aux_pin_a_out}, 16'h0002);
		@(posedge clk_in);
		start <= 1'b1;
		n = 0;
		while (aux_pin_a_out !== 1'b1 && n < 40) begin
			@(posedge clk_in);
			#1 n++;
		end
		chk("sync delay", 16'(n >= lo && n <= hi), 16'h0001);
		@(posedge clk_in);
		start <= 1'b0;
		tick(20);
		chk("sync low", aux_pin_a_out, 16'h0000);
		$display("start test end");
	endtask
	task automatic t_hold;
		wr(PIN_FUNC_CFG_ADDR, 16'h0004);
		@(posedge clk_in);
		sync_in_n_in <= 1'b0;
		tick(3);
		chk("hold", {core_reset_out, modulator_reset_out}, 16'h0003);
		@(posedge clk_in);
		sync_in_n_in <= 1'b1;
		tick(2);
		chk("release", {core_reset_out, modulator_reset_out}, 16'h0000);
		$display("sync hold test end");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		repeat (3000) @(posedge clk_in);
		n_mismatch++;
		final_report;
	end
	initial begin
		{rst_in, ce_in, wr_in, rd_in, cont_tx_in, stream_data_clock_in} = 6'h30;
		{ready_n_in, sync_in_n_in, start_en, start} = 4'h4;
		clk_div_sel_in    = DIV_BY_2;
		active_channel_in = 4'h0;
		addr_in           = 8'h00;
		wdata_in          = 16'h0000;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		t_regs;
		t_chan;
		t_aux;
		t_stream;
		t_start(DIV_BY_2, 3, 4);
		t_start(DIV_BY_4, 5, 8);
		t_start(DIV_BY_8, 9, 16);
		t_hold;
		final_report;
	end
endmodule
